// ---- inc/ctalu_pkg.sv ----
package ctalu_pkg;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_TRANSFER   = 5'h00,
        OP_PSTORE     = 5'h01,
        OP_PLOAD      = 5'h02,
        OP_PUSH       = 5'h03,
        OP_POP        = 5'h04,
        OP_ADD        = 5'h05,
        OP_SUB        = 5'h06,
        OP_CARRY_SUM_OP       = 5'h07,
        OP_BORROW_DIFFERENCE_OP       = 5'h08,
        OP_INC        = 5'h09,
        OP_DEC        = 5'h0a,
        OP_ADDS       = 5'h0b,
        OP_WORD_SMALL_DECREMENT_OP       = 5'h0c,
        OP_DAA        = 5'h0d,
        OP_DAS        = 5'h0e,
        OP_MUL        = 5'h0f,
        OP_DIV        = 5'h10,
        OP_CMP        = 5'h11,
        OP_NEG        = 5'h12,
        OP_AND        = 5'h13,
        OP_OR         = 5'h14,
        OP_XOR        = 5'h15,
        OP_NOT        = 5'h16
    } ctalu_op_e;

    // Addressing forms of the transfer operation
    typedef enum logic [2:0] {
        AM_REG        = 3'h0,
        AM_IND        = 3'h1,
        AM_DISP       = 3'h2,
        AM_ABS16      = 3'h3,
        AM_ABS8       = 3'h4,
        AM_IMM        = 3'h5,
        AM_PREDEC     = 3'h6,
        AM_POSTINC    = 3'h7
    } ctalu_am_e;

    typedef enum logic [2:0] {
        ST_IDLE       = 3'h0,
        ST_MEM        = 3'h1,
        ST_EWAIT      = 3'h2,
        ST_EACC       = 3'h3,
        ST_DONE       = 3'h4
    } ctalu_st_e;

    localparam logic [2:0]  SP_IDX      = 3'h7;
    localparam logic [7:0]  ABS8_PAGE   = 8'hff;
    localparam logic [15:0] STEP_BYTE   = 16'h0001;
    localparam logic [15:0] STEP_WORD   = 16'h0002;
    localparam logic [15:0] REG_RST     = 16'h0000;
    localparam int          FL_N        = 3;
    localparam int          FL_Z        = 2;
    localparam int          FL_V        = 1;
    localparam int          FL_C        = 0;

    // Byte ops: rd/rs bit 3 set picks the low half
    typedef struct packed {
        ctalu_op_e   op;
        ctalu_am_e   am;
        logic        word;
        logic        to_mem;
        logic [3:0]  rd;
        logic [3:0]  rs;
        logic [15:0] imm;
        logic [15:0] disp;
    } ctalu_req_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ctalu_bus_s;
endpackage

// ---- hw/ctalu_core.sv ----
`timescale 1ns/100ps
// Functional notes
// - Transfer: reg, memory or immediate.
// - Short absolute form is byte only.
// - Peripheral store: byte on E strobe.
// - Peripheral load: byte on E strobe.
// - Push: pointer minus two, store word.
// - Pop: load word, pointer plus two.
// - Subtract takes no immediate.
// - Word add/sub/compare: registers only.
// - Carry add/sub: byte, use carry.
// - Inc/dec byte by one.
// - Word small step: one or two.
// - Decimal adjust byte result.
// - Multiply 8x8 to 16 bits.
// - Divide 16 by 8 bits.
// - Compare sets flags only.
// - Negate: zero minus byte.
// - AND byte, reg or immediate.
// - OR byte, reg or immediate.
// - XOR byte, reg or immediate.
// - Invert flips byte bits.
// - Word access clears address bit 0.
// - Pointer step: byte 1, word 2.
module ctalu_core
    import ctalu_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_START,
    input  wire ctalu_req_s  I_REQ,
    input  wire logic        I_MEM_ACK,
    input  wire logic [15:0] I_MEM_RDATA,
    input  wire logic        I_E_CLK,
    output logic             O_BUSY,
    output logic             O_DONE,
    output logic             O_ILLEGAL,
    output ctalu_bus_s       O_BUS,
    output logic [3:0]       O_FLAGS,
    output logic [15:0]      O_STACK_PTR
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       rst_sync;
        logic [2:0]       e_sync;
        ctalu_st_e        st;
        ctalu_req_s       req;
        logic [7:0][15:0] gr;
        logic [3:0]       flags;
        ctalu_bus_s       bus;
        logic             busy;
        logic             done;
        logic             illegal;
    } ctalu_state_s;

    ctalu_state_s s_q;
    ctalu_state_s s_d;
    logic         rst_n;

    assign rst_n = s_q.rst_sync[1];

    function automatic logic [7:0] rd8(input logic [7:0][15:0] g,
                                       input logic [3:0] sel);
        rd8 = sel[3] ? g[sel[2:0]][7:0] : g[sel[2:0]][15:8];
    endfunction

    function automatic logic [7:0][15:0] wr8(
        input logic [7:0][15:0] g, input logic [3:0] sel,
        input logic [7:0] v);
        logic [7:0][15:0] r;
        r = g;
        if (sel[3]) begin
            r[sel[2:0]][7:0] = v;
        end else begin
            r[sel[2:0]][15:8] = v;
        end
        wr8 = r;
    endfunction

    // N and Z of a result of either width
    function automatic logic [1:0] nz(input logic [15:0] v,
                                      input logic w);
        nz = w ? {v[15], v == 16'h0000} : {v[7], v[7:0] == 8'h00};
    endfunction

    // Bit zero forced low on word accesses
    function automatic logic [15:0] align(input logic [15:0] a,
                                          input logic w);
        align = w ? {a[15:1], 1'b0} : a;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        ctalu_req_s  r;
        logic [15:0] a16;
        logic [15:0] b16;
        logic [16:0] sum;
        logic [8:0]  s8;
        logic [7:0]  a8;
        logic [7:0]  b8;
        logic [7:0]  res8;
        logic [15:0] step;
        logic [15:0] ea;
        logic [7:0]  adj;
        logic        cin;
        logic        bad;
        r    = I_REQ;
        s_d  = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        // The second and third stages feed the edge detect
        s_d.e_sync   = {s_q.e_sync[1:0], I_E_CLK};
        s_d.done     = 1'b0;
        s_d.illegal  = 1'b0;
        a8   = rd8(s_q.gr, r.rd);
        b8   = (r.am == AM_IMM) ? r.imm[7:0] : rd8(s_q.gr, r.rs);
        a16  = s_q.gr[r.rd[2:0]];
        b16  = s_q.gr[r.rs[2:0]];
        cin  = s_q.flags[FL_C];
        step = r.word ? STEP_WORD : STEP_BYTE;
        sum  = 17'h00000;
        s8   = 9'h000;
        res8 = 8'h00;
        adj  = 8'h00;
        ea   = 16'h0000;
        bad  = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                if (I_START) begin
                    s_d.req = r;
                    unique case (r.op)
                        OP_TRANSFER, OP_PSTORE, OP_PLOAD, OP_PUSH,
                        OP_POP: begin
                            bad = (r.am == AM_ABS8 && r.word)
                                | ((r.op == OP_PSTORE || r.op == OP_PLOAD)
                                   && r.word);
                            if (r.op == OP_PUSH || r.op == OP_POP) begin
                                s_d.req.word   = 1'b1;
                                s_d.req.rs     = {1'b0, SP_IDX};
                                s_d.req.am     = (r.op == OP_PUSH) ?
                                                 AM_PREDEC : AM_POSTINC;
                                s_d.req.to_mem = (r.op == OP_PUSH);
                                step           = STEP_WORD;
                            end
                            // rs is the pointer
                            ea = s_q.gr[s_d.req.rs[2:0]];
                            unique case (s_d.req.am)
                                AM_DISP:    ea = ea + r.disp;
                                AM_ABS16:   ea = r.imm;
                                AM_ABS8:    ea = {ABS8_PAGE, r.imm[7:0]};
                                AM_PREDEC:  ea = ea - step;
                                default:    ea = ea;
                            endcase
                            if (bad) begin
                                s_d.illegal = 1'b1;
                                s_d.done    = 1'b1;
                            end else if (s_d.req.am == AM_REG ||
                                         s_d.req.am == AM_IMM) begin
                                b16 = (r.am == AM_IMM) ? r.imm : b16;
                                if (r.word) begin
                                    s_d.gr[r.rd[2:0]] = b16;
                                    s_d.flags[FL_N:FL_Z] = nz(b16, 1'b1);
                                end else begin
                                    s_d.gr = wr8(s_q.gr, r.rd, b8);
                                    s_d.flags[FL_N:FL_Z] =
                                        nz({8'h00, b8}, 1'b0);
                                end
                                s_d.flags[FL_V] = 1'b0;
                                s_d.done = 1'b1;
                            end else begin
                                if (s_d.req.am == AM_PREDEC) begin
                                    s_d.gr[s_d.req.rs[2:0]] = ea;
                                end
                                s_d.bus.addr  = align(ea, s_d.req.word);
                                s_d.bus.word  = s_d.req.word;
                                s_d.bus.we    = s_d.req.to_mem;
                                s_d.bus.wdata = s_d.req.word ?
                                    s_q.gr[r.rd[2:0]] :
                                    {8'h00, rd8(s_q.gr, r.rd)};
                                s_d.busy = 1'b1;
                                if (r.op == OP_PSTORE || r.op == OP_PLOAD)
                                begin
                                    s_d.bus.we = (r.op == OP_PSTORE);
                                    s_d.st     = ST_EWAIT;
                                end else begin
                                    s_d.bus.req = 1'b1;
                                    s_d.st      = ST_MEM;
                                end
                            end
                        end
                        OP_ADD, OP_SUB, OP_CMP: begin
                            bad = (r.op == OP_SUB && r.am == AM_IMM)
                                | (r.word && r.am == AM_IMM);
                            if (r.word) begin
                                sum = (r.op == OP_ADD) ?
                                    {1'b0, a16} + {1'b0, b16} :
                                    {1'b0, a16} - {1'b0, b16};
                                s_d.flags[FL_N:FL_Z] = nz(sum[15:0], 1'b1);
                                s_d.flags[FL_V] = (r.op == OP_ADD) ?
                                    (a16[15] == b16[15]) &&
                                    (sum[15] != a16[15]) :
                                    (a16[15] != b16[15]) &&
                                    (sum[15] != a16[15]);
                                s_d.flags[FL_C] = sum[16];
                                if (r.op != OP_CMP) begin
                                    s_d.gr[r.rd[2:0]] = sum[15:0];
                                end
                            end else begin
                                s8 = (r.op == OP_ADD) ?
                                    {1'b0, a8} + {1'b0, b8} :
                                    {1'b0, a8} - {1'b0, b8};
                                res8 = s8[7:0];
                                if (r.op != OP_CMP) begin
                                    s_d.gr = wr8(s_q.gr, r.rd, res8);
                                end
                            end
                        end
                        OP_CARRY_SUM_OP, OP_BORROW_DIFFERENCE_OP: begin
                            bad = r.word;
                            s8 = (r.op == OP_CARRY_SUM_OP) ?
                                {1'b0, a8} + {1'b0, b8} + {8'h00, cin} :
                                {1'b0, a8} - {1'b0, b8} - {8'h00, cin};
                            res8 = s8[7:0];
                            s_d.gr = wr8(s_q.gr, r.rd, res8);
                        end
                        OP_INC, OP_DEC: begin
                            res8 = (r.op == OP_INC) ? a8 + 8'h01 : a8 - 8'h01;
                            s_d.gr = wr8(s_q.gr, r.rd, res8);
                            s_d.flags[FL_N:FL_Z] = nz({8'h00, res8}, 1'b0);
                            s_d.flags[FL_V] = (r.op == OP_INC) ?
                                (a8 == 8'h7f) : (a8 == 8'h80);
                        end
                        OP_ADDS, OP_WORD_SMALL_DECREMENT_OP: begin
                            bad = (r.imm != STEP_BYTE && r.imm != STEP_WORD);
                            if (!bad) begin
                                s_d.gr[r.rd[2:0]] = (r.op == OP_ADDS) ?
                                    a16 + r.imm : a16 - r.imm;
                            end
                        end
                        OP_DAA, OP_DAS: begin
                            if (s_q.flags[FL_C] || a8 > 8'h99) begin
                                adj[7:4] = 4'h6;
                            end
                            if ((r.op == OP_DAA && a8[3:0] > 4'h9) ||
                                r.imm[0]) begin
                                adj[3:0] = 4'h6;
                            end
                            res8 = (r.op == OP_DAA) ? a8 + adj : a8 - adj;
                            s_d.gr = wr8(s_q.gr, r.rd, res8);
                            s_d.flags[FL_N:FL_Z] = nz({8'h00, res8}, 1'b0);
                            s_d.flags[FL_C] = adj[5];
                        end
                        OP_MUL: begin
                            s_d.gr[r.rd[2:0]] =
                                16'({8'h00, s_q.gr[r.rd[2:0]][7:0]} *
                                    {8'h00, rd8(s_q.gr, r.rs)});
                        end
                        OP_DIV: begin
                            b8 = rd8(s_q.gr, r.rs);
                            if (b8 != 8'h00) begin
                                s_d.gr[r.rd[2:0]] = {
                                    8'(a16 % {8'h00, b8}),
                                    8'(a16 / {8'h00, b8})};
                            end
                            s_d.flags[FL_Z] = (b8 == 8'h00);
                        end
                        OP_NEG: begin
                            s8 = 9'h000 - {1'b0, a8};
                            a8 = 8'h00;
                            b8 = rd8(s_q.gr, r.rd);
                            res8 = s8[7:0];
                            s_d.gr = wr8(s_q.gr, r.rd, res8);
                        end
                        default: begin
                            unique case (r.op)
                                OP_AND:  res8 = a8 & b8;
                                OP_OR:   res8 = a8 | b8;
                                OP_XOR:  res8 = a8 ^ b8;
                                default: res8 = ~a8;
                            endcase
                            s_d.gr = wr8(s_q.gr, r.rd, res8);
                            s_d.flags[FL_N:FL_Z] = nz({8'h00, res8}, 1'b0);
                            s_d.flags[FL_V] = 1'b0;
                        end
                    endcase
                    // Byte add/sub flags
                    if (!r.word && (r.op == OP_ADD || r.op == OP_SUB ||
                        r.op == OP_CMP || r.op == OP_CARRY_SUM_OP ||
                        r.op == OP_BORROW_DIFFERENCE_OP || r.op == OP_NEG)) begin
                        s_d.flags[FL_N:FL_Z] = nz({8'h00, res8}, 1'b0);
                        s_d.flags[FL_C] = s8[8];
                        s_d.flags[FL_V] = (r.op == OP_ADD ||
                            r.op == OP_CARRY_SUM_OP) ?
                            (a8[7] == b8[7]) && (res8[7] != a8[7]) :
                            (a8[7] != b8[7]) && (res8[7] != a8[7]);
                    end
                    if (bad) begin
                        s_d.gr    = s_q.gr;
                        s_d.flags = s_q.flags;
                        s_d.st    = ST_IDLE;
                        s_d.busy  = 1'b0;
                    end
                    s_d.illegal = bad;
                    s_d.done    = (s_d.st == ST_IDLE);
                end
            end
            ST_EWAIT: begin
                // Rising E edge: access starts, held until ack
                if (s_q.e_sync[1] && !s_q.e_sync[2]) begin
                    s_d.bus.req = 1'b1;
                    s_d.st      = ST_EACC;
                end
            end
            ST_MEM, ST_EACC: begin
                if (I_MEM_ACK) begin
                    s_d.bus.req = 1'b0;
                    s_d.st      = ST_DONE;
                    if (!s_q.req.to_mem && !s_q.bus.we) begin
                        if (s_q.req.word) begin
                            s_d.gr[s_q.req.rd[2:0]] = I_MEM_RDATA;
                        end else begin
                            s_d.gr = wr8(s_q.gr, s_q.req.rd,
                                         I_MEM_RDATA[7:0]);
                        end
                    end
                    s_d.flags[FL_N:FL_Z] = s_q.bus.we ?
                        nz(s_q.bus.wdata, s_q.req.word) :
                        nz(I_MEM_RDATA, s_q.req.word);
                    s_d.flags[FL_V] = 1'b0;
                end
            end
            ST_DONE: begin
                if (s_q.req.am == AM_POSTINC) begin
                    s_d.gr[s_q.req.rs[2:0]] = s_q.gr[s_q.req.rs[2:0]] +
                        (s_q.req.word ? STEP_WORD : STEP_BYTE);
                end
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st   = ST_IDLE;
            end
            default: begin
                s_d.st   = ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s_q <= '0;
        end else if (!rst_n) begin
            s_q          <= '0;
            s_q.rst_sync <= s_d.rst_sync;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_BUSY      = s_q.busy;
    assign O_DONE      = s_q.done;
    assign O_ILLEGAL   = s_q.illegal;
    assign O_BUS       = s_q.bus;
    assign O_FLAGS     = s_q.flags;
    assign O_STACK_PTR = s_q.gr[SP_IDX];

endmodule

// ---- tb/ctalu_core_sva.sv ----
`timescale 1ns/100ps
module ctalu_core_sva
    import ctalu_pkg::*;
(
    input wire logic        I_REF_CLK,
    input wire logic        I_RSTN,
    input wire logic        I_START,
    input wire ctalu_req_s  I_REQ,
    input wire logic        I_MEM_ACK,
    input wire logic [15:0] I_MEM_RDATA,
    input wire logic        I_E_CLK,
    input wire logic        O_BUSY,
    input wire logic        O_DONE,
    input wire logic        O_ILLEGAL,
    input wire ctalu_bus_s  O_BUS,
    input wire logic [3:0]  O_FLAGS,
    input wire logic [15:0] O_STACK_PTR
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RSTN);
    sequence s_take;
        I_START && !O_BUSY;
    endsequence
    sequence s_ack;
        O_BUS.req && I_MEM_ACK;
    endsequence
    // Slow strobe: request waits
    sequence s_pe;
        !O_BUS.req ##[1:60] (O_BUS.req && !O_BUS.word);
    endsequence
    AST_ILL_DONE: assert property (O_ILLEGAL |-> O_DONE)
        else $error("refusal without completion");
    AST_REG_DONE: assert property (s_take and I_REQ.op >= OP_ADD
        |=> O_DONE && !O_BUS.req) else $error("register op late or on bus");
    AST_ALIGN: assert property (O_BUS.req && O_BUS.word
        |-> !O_BUS.addr[0]) else $error("odd word address");
    AST_HOLD: assert property (O_BUS.req && !I_MEM_ACK
        |=> O_BUS.req && $stable(O_BUS)) else $error("bus dropped early");
    AST_ACK_DONE: assert property (s_ack |=> !O_BUS.req ##1 O_DONE)
        else $error("no completion after ack");
    AST_PUSH: assert property (s_take and I_REQ.op == OP_PUSH |=>
        O_STACK_PTR == $past(O_STACK_PTR) - 16'h0002 && O_BUS.we
        && O_BUS.req && O_BUS.addr == O_STACK_PTR)
        else $error("push pointer wrong");
    AST_ABS8: assert property (s_take and I_REQ.op == OP_TRANSFER
        && I_REQ.am == AM_ABS8 && I_REQ.word |=> O_ILLEGAL)
        else $error("word short absolute accepted");
    AST_SUB_IMM: assert property (s_take and I_REQ.op == OP_SUB
        && I_REQ.am == AM_IMM |=> O_ILLEGAL) else $error("sub imm taken");
    AST_STEP: assert property (s_take and I_REQ.op inside {OP_ADDS,
        OP_WORD_SMALL_DECREMENT_OP} && !(I_REQ.imm inside {16'h0001, 16'h0002})
        |=> O_ILLEGAL) else $error("bad small step accepted");
    AST_CARRY_W: assert property (s_take and I_REQ.word
        && I_REQ.op inside {OP_CARRY_SUM_OP, OP_BORROW_DIFFERENCE_OP} |=> O_ILLEGAL)
        else $error("word carry op accepted");
    AST_PE: assert property (s_take and !I_REQ.word
        && I_REQ.op inside {OP_PSTORE, OP_PLOAD} |=> s_pe)
        else $error("peripheral access not byte or not delayed");
endmodule
bind ctalu_core ctalu_core_sva u_ctalu_core_sva (.*);

// ---- tb/ctalu_mem_model.sv ----
`timescale 1ns/100ps
module ctalu_mem_model
    import ctalu_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire ctalu_bus_s  i_bus,
    output logic             o_ack,
    output logic [15:0]      o_rdata,
    output logic             o_e_clk
);
    logic [7:0]  mem [256];
    logic [3:0]  ediv_q;
    logic [7:0]  a;
    assign a = i_bus.addr[7:0];
    assign o_e_clk = ediv_q[3];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        logic go;
        go = ($urandom % 3) != 0;
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            ediv_q <= 4'h0;
            o_rdata <= 16'h0000;
        end else begin
            ediv_q <= ediv_q + 4'h1;
            o_ack <= i_bus.req && !o_ack && go;
            // Idle data scrambled
            o_rdata <= ~o_rdata;
            if (i_bus.req && !o_ack && go) begin
                if (i_bus.word) begin
                    o_rdata <= {mem[a], mem[a | 8'h01]};
                end else begin
                    o_rdata <= {8'h00, mem[a]};
                end
                if (i_bus.we && i_bus.word) begin
                    mem[a] <= i_bus.wdata[15:8];
                    mem[a | 8'h01] <= i_bus.wdata[7:0];
                end else if (i_bus.we) begin
                    mem[a] <= i_bus.wdata[7:0];
                end
            end
        end
    end
endmodule

// ---- tb/ctalu_core_tb.sv ----
`timescale 1ns/100ps
module ctalu_core_tb;
    import ctalu_pkg::*;
    logic        clk, rst_n, start, ack, e_clk, busy, done, ill, ill_q;
    ctalu_req_s  req;
    ctalu_bus_s  bus;
    logic [15:0] rdata, sp, wr_a, wr_d, a, b, imm;
    logic [3:0]  flags;
    int          error_cnt, n_checks, cyc;
    ctalu_op_e   ops [13] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
        OP_NOT, OP_NEG, OP_INC, OP_DEC, OP_MUL, OP_DIV, OP_CMP, OP_ADDS};
    ctalu_req_s  bad [6] = '{'{OP_TRANSFER, AM_ABS8, 1, 0, 0, 9, 0, 0},
        '{OP_SUB, AM_IMM, 0, 0, 8, 9, 5, 0}, '{OP_ADD, AM_IMM, 1, 0, 0, 9, 5, 0},
        '{OP_CARRY_SUM_OP, AM_REG, 1, 0, 0, 1, 0, 0}, '{OP_ADDS, AM_REG, 1, 0, 0, 1, 3, 0},
        '{OP_PSTORE, AM_IND, 1, 1, 8, 6, 0, 0}};
    ctalu_core u_ctalu_core (.I_REF_CLK(clk), .I_RSTN(rst_n), .I_START(start),
        .I_REQ(req), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata), .I_E_CLK(e_clk),
        .O_BUSY(busy), .O_DONE(done), .O_ILLEGAL(ill), .O_BUS(bus),
        .O_FLAGS(flags), .O_STACK_PTR(sp));
    ctalu_mem_model u_ctalu_mem_model (.i_clk(clk), .i_rst_n(rst_n),
        .i_bus(bus), .o_ack(ack), .o_rdata(rdata), .o_e_clk(e_clk));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (bus.req && ack && bus.we) begin
            wr_a <= bus.addr;
            wr_d <= bus.wdata;
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(ctalu_req_s r);
        int k;
        @(posedge clk) #1;
        req = r;
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 80) begin
            @(posedge clk) #1;
            k++;
        end
        ill_q = ill;
        if (k == 80) chk("done", 16'h0001, 16'h0000);
    endtask
    task automatic ld(logic [3:0] r, logic [15:0] v);
        run('{OP_TRANSFER, AM_IMM, 1'b1, 1'b0, r, 4'h0, v, 16'h0000});
    endtask
    // Registers seen via stores through R6
    task automatic peek(logic [3:0] r, logic [15:0] e);
        run('{OP_TRANSFER, AM_IND, 1'b1, 1'b1, r, 4'h6, 16'h0, 16'h0});
        chk("reg", e, wr_d);
    endtask
    function automatic logic [15:0] f_res(ctalu_op_e op, logic [15:0] a,
        logic [15:0] b, logic [15:0] i);
        case (op)
            OP_ADD:  return {a[15:8], a[7:0] + b[7:0]};
            OP_SUB:  return {a[15:8], a[7:0] - b[7:0]};
            OP_AND:  return {a[15:8], a[7:0] & b[7:0]};
            OP_OR:   return {a[15:8], a[7:0] | b[7:0]};
            OP_XOR:  return {a[15:8], a[7:0] ^ b[7:0]};
            OP_NOT:  return {a[15:8], ~a[7:0]};
            OP_NEG:  return {a[15:8], 8'h00 - a[7:0]};
            OP_INC:  return {a[15:8], a[7:0] + 8'h01};
            OP_DEC:  return {a[15:8], a[7:0] - 8'h01};
            OP_MUL:  return 16'(a[7:0] * b[7:0]);
            OP_DIV:  return {8'(a % b[7:0]), 8'(a / b[7:0])};
            OP_ADDS: return a + i;
            default: return a;
        endcase
    endfunction
    function automatic logic [3:0] f_flg(logic s, logic [7:0] a,
        logic [7:0] b);
        logic [8:0] r;
        r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        return {r[7], r[7:0] == 8'h00, (s ? a[7] != b[7] : a[7] == b[7])
            && r[7] != a[7], r[8]};
    endfunction
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        req = '0;
        a = $urandom(50);
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        ld(4'h6, 16'h0041);
        for (int i = 0; i < 12; i++) begin
            foreach (ops[j]) begin
                b = 16'($urandom) | 16'h0001;
                a = (i == 0) ? b : 16'($urandom);
                // Keep the quotient within a byte
                a[15:8] = a[15:8] % b[7:0];
                imm = 16'(i % 2 + 1);
                ld(4'h0, a);
                ld(4'h1, b);
                run('{ops[j], AM_REG, ops[j] == OP_ADDS, 1'b0,
                    (ops[j] == OP_ADDS) ? 4'h0 : 4'h8, 4'h9, imm, 16'h0});
                if (ops[j] inside {OP_ADD, OP_SUB, OP_CMP})
                    chk("flags", 16'(f_flg(ops[j] != OP_ADD, a[7:0],
                        b[7:0])), 16'(flags));
                peek(4'h0, f_res(ops[j], a, b, imm));
            end
        end
        chk("odd word addr", 16'h0040, wr_a);
        $display("test arithmetic and logic done");
        ld(4'h0, 16'h00ff);
        ld(4'h1, 16'h0001);
        run('{OP_ADD, AM_REG, 1'b0, 1'b0, 4'h8, 4'h9, 16'h0, 16'h0});
        run('{OP_CARRY_SUM_OP, AM_REG, 1'b0, 1'b0, 4'h8, 4'h9, 16'h0, 16'h0});
        peek(4'h0, 16'h0002);
        ld(4'h0, 16'h0009);
        run('{OP_ADD, AM_REG, 1'b0, 1'b0, 4'h8, 4'h9, 16'h0, 16'h0});
        run('{OP_DAA, AM_REG, 1'b0, 1'b0, 4'h8, 4'h9, 16'h0, 16'h0});
        peek(4'h0, 16'h0010);
        ld(4'h0, 16'h1234);
        foreach (bad[k]) begin
            run(bad[k]);
            chk("refused", 16'h0001, 16'(ill_q));
        end
        peek(4'h0, 16'h1234);
        $display("test carry and refusals done");
        ld(4'h7, 16'h0080);
        ld(4'h0, 16'hbeef);
        run('{OP_PUSH, AM_PREDEC, 1'b1, 1'b1, 4'h0, 4'h7, 16'h0, 16'h0});
        chk("push sp", 16'h007e, sp);
        chk("push addr", 16'h007e, wr_a);
        run('{OP_POP, AM_POSTINC, 1'b1, 1'b0, 4'h2, 4'h7, 16'h0, 16'h0});
        chk("pop sp", 16'h0080, sp);
        peek(4'h2, 16'hbeef);
        run('{OP_TRANSFER, AM_POSTINC, 1'b1, 1'b0, 4'h3, 4'h7, 16'h0, 16'h0});
        chk("postinc sp", 16'h0082, sp);
        run('{OP_PSTORE, AM_IND, 1'b0, 1'b1, 4'h0, 4'h6, 16'h0, 16'h0});
        chk("pe store", 16'h41be, {wr_a[7:0], wr_d[7:0]});
        run('{OP_PLOAD, AM_IND, 1'b0, 1'b0, 4'ha, 4'h6, 16'h0, 16'h0});
        peek(4'h2, 16'hbebe);
        $display("test stack and peripheral done");
        tally_and_finish();
    end
endmodule
